// [logic/plrs_device.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Hold reset while supplies out of range
// - Board straps short reset delay high
// - Short reset delay lasts 4 to 12 ms
// - Init mode: periphery loaded by 120 ms
// - Update mode: full configuration by 120 ms
// - Host holds link reset at least 100 ms
// - Host releases reset 20 ms before training; the device enters training on release, with no wait
// - Link reaches L0 within 100 ms
// - Power-on to L0 within 200 ms
// - Init mode: hard reset on periphery loaded
// - Update mode: link reset release initializes logic
// - Init mode link carries core images, applications
// - Update mode link serves applications, core updates
// - Host checks Gen 2 rate, retrains
// - Init mode accepts three conventional schemes
// - Update mode: no compression or encryption
module plrs_device
	import plrs_pkg::*;
#(
	parameter int MS_CYCLES = CYC_PER_MS // Clock cycles in one millisecond
)
(
	input wire logic clk,
	input wire logic nrst,
	plrs_link_if.dev link,
	input wire logic supplies_good,
	input wire logic reset_delay_select_strap,
	input wire plrs_pkg::plrs_mode_e mode,
	input wire plrs_pkg::plrs_scheme_e config_scheme,
	input wire logic config_done,
	input wire logic training_done,
	input wire logic gen2_capable,
	output logic core_reset_n,
	output logic config_start,
	output logic hard_reset_pulse,
	output logic link_app_enable,
	output logic core_image_over_link,
	output logic config_timeout,
	output logic l0_timeout,
	output logic wake_timeout,
	output logic scheme_error
);
	import plrs_pkg::*;

	// ==============================
	// Sequencer states
	typedef enum logic [2:0]
	{
		PLRS_ST_OFF = 3'h0,
		PLRS_ST_POR = 3'h1,
		PLRS_ST_CONFIG = 3'h3,
		PLRS_ST_WAIT_LINK = 3'h2,
		PLRS_ST_TRAIN = 3'h6,
		PLRS_ST_L0 = 3'h7
	} plrs_dev_state_e;

	plrs_dev_state_e state; // Current state
	plrs_dev_state_e next_state; // Next state
	logic [TICK_W-1:0] tick_cnt; // Millisecond prescaler
	logic ms_tick; // One cycle per ms
	logic [MS_W-1:0] phase_ms; // Ms spent in current phase
	logic [MS_W-1:0] power_ms; // Ms since supplies good
	logic [MS_W-1:0] perst_ms; // Ms since link reset release
	// Rate the link will train to, registered twice before it reaches the pins
	logic [1:0] rate; // Trained rate

	// ==============================
	// Decode
	// Last prescaler count of a millisecond; the prescaler runs free
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYCLES - 1);
	// Power-on reset delay in whole milliseconds
	localparam logic [MS_W-1:0] POR_MS = MS_W'(POR_DELAY_MS);
	assign ms_tick = (tick_cnt == TICK_LAST);
	wire por_done = (phase_ms >= POR_MS) && reset_delay_select_strap;
	wire scheme_ok = (config_scheme != 2'h3);
	wire init_mode = (mode == PLRS_MODE_INIT);
	// Training may begin once configured and the link reset stands released
	wire train_go = init_mode ? 1'b1 : link.perst_n;
	wire cfg_late = (power_ms >= MS_W'(PERIPH_DEADLINE_MS));
	wire l0_late = (perst_ms >= MS_W'(L0_DEADLINE_MS));
	wire wake_late = (power_ms >= MS_W'(WAKE_DEADLINE_MS));

	// ==============================
	// Next state
	always_comb
	begin
		next_state = state;
		case (state)
			// Unpowered: wait for all supplies in range
			PLRS_ST_OFF:
				if (supplies_good)
					next_state = PLRS_ST_POR;
			// Power-on reset delay; a low strap keeps the device here
			PLRS_ST_POR:
				if (por_done)
					next_state = PLRS_ST_CONFIG;
			// Conventional load; an illegal scheme never completes
			PLRS_ST_CONFIG:
				if (config_done && scheme_ok)
					next_state = PLRS_ST_WAIT_LINK;
			// Configured, link held until its reset is released
			PLRS_ST_WAIT_LINK:
				if (train_go && link.perst_n)
					next_state = PLRS_ST_TRAIN;
			// Link training in progress
			PLRS_ST_TRAIN:
				if (training_done)
					next_state = PLRS_ST_L0;
			// Active state; host may ask for a retrain
			PLRS_ST_L0:
				if (link.retrain_req)
					next_state = PLRS_ST_TRAIN;
			// Unused codes fall back to the unpowered state
			default:
				next_state = PLRS_ST_OFF;
		endcase
		// Supply loss or link reset restarts the relevant part
		if (!supplies_good)
			next_state = PLRS_ST_OFF;
		else if (!link.perst_n && (state == PLRS_ST_TRAIN || state == PLRS_ST_L0))
			next_state = PLRS_ST_WAIT_LINK;
	end

	// ==============================
	// State and timers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= PLRS_ST_OFF;
			tick_cnt <= '0;
			phase_ms <= '0;
			power_ms <= '0;
			perst_ms <= '0;
		end
		else
		begin
			state <= next_state;
			// Free-running millisecond prescaler
			tick_cnt <= ms_tick ? '0 : tick_cnt + 1'b1;
			// Phase timer restarts on every state change, saturates at the top
			if (next_state != state)
				phase_ms <= '0;
			else if (ms_tick && phase_ms != '1)
				phase_ms <= phase_ms + 1'b1;
			// Time since power-up, the reference for the wake-up deadlines
			if (!supplies_good)
				power_ms <= '0;
			else if (ms_tick && power_ms != '1)
				power_ms <= power_ms + 1'b1;
			// Time since link reset release, the reference for the active-state deadline
			if (!link.perst_n)
				perst_ms <= '0;
			else if (ms_tick && perst_ms != '1)
				perst_ms <= perst_ms + 1'b1;
		end
	end

	// ==============================
	// Outputs
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			core_reset_n <= 1'b0;
			config_start <= 1'b0;
			hard_reset_pulse <= 1'b0;
			link_app_enable <= 1'b0;
			core_image_over_link <= 1'b0;
			config_timeout <= 1'b0;
			l0_timeout <= 1'b0;
			wake_timeout <= 1'b0;
			scheme_error <= 1'b0;
			rate <= RATE_GEN1;
			link.ready_for_training <= 1'b0;
			link.link_l0 <= 1'b0;
			link.link_rate <= RATE_GEN1;
		end
		else
		begin
			// Core held in reset until supplies good and POR delay over
			core_reset_n <= supplies_good && state != PLRS_ST_OFF && state != PLRS_ST_POR;
			config_start <= (state == PLRS_ST_POR) && por_done;
			// Init mode hard reset fires on periphery loaded, never on link reset
			hard_reset_pulse <= init_mode && state == PLRS_ST_CONFIG && config_done && scheme_ok;
			// Link interface ready once the periphery or full image is loaded
			link.ready_for_training <= (state == PLRS_ST_WAIT_LINK) || (state == PLRS_ST_TRAIN);
			// Active-state flag follows the state it is entering
			link.link_l0 <= (next_state == PLRS_ST_L0);
			// Rate chosen from capability, shown one cycle later
			rate <= gen2_capable ? RATE_GEN2 : RATE_GEN1;
			link.link_rate <= rate;
			// User traffic and image delivery only while active
			link_app_enable <= (next_state == PLRS_ST_L0);
			core_image_over_link <= (next_state == PLRS_ST_L0);
			// Level while an illegal scheme blocks the load
			scheme_error <= (state == PLRS_ST_CONFIG) && !scheme_ok;
			// Sticky timeouts, cleared only by supply loss; set wins
			if (state == PLRS_ST_CONFIG && cfg_late)
				config_timeout <= 1'b1;
			else if (!supplies_good)
				config_timeout <= 1'b0;
			if (state == PLRS_ST_TRAIN && link.perst_n && l0_late)
				l0_timeout <= 1'b1;
			else if (!supplies_good)
				l0_timeout <= 1'b0;
			if (state != PLRS_ST_L0 && state != PLRS_ST_OFF && wake_late)
				wake_timeout <= 1'b1;
			else if (!supplies_good)
				wake_timeout <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [logic/plrs_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Host root port end: drives link reset and checks trained rate
module plrs_host
	import plrs_pkg::*;
#(
	parameter int MS_CYCLES = CYC_PER_MS // Clock cycles in one millisecond
)
(
	input wire logic clk,
	input wire logic nrst,
	plrs_link_if.host link,
	input wire logic power_good,
	input wire logic expect_gen2,
	output logic link_up,
	output logic rate_ok,
	output logic retrain_count
);
	import plrs_pkg::*;

	// ==============================
	// Host states
	typedef enum logic [1:0]
	{
		PLRS_H_RESET = 2'h0,
		PLRS_H_RELEASE = 2'h1,
		PLRS_H_UP = 2'h3,
		PLRS_H_CHECK = 2'h2
	} plrs_host_state_e;

	plrs_host_state_e state; // Current state
	plrs_host_state_e next_state; // Next state
	logic [TICK_W-1:0] tick_cnt; // Millisecond prescaler
	logic [MS_W-1:0] ms; // Ms in current state
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYCLES - 1);
	wire ms_tick = (tick_cnt == TICK_LAST);
	wire hold_done = (ms >= MS_W'(PERST_ACTIVE_MIN_MS));
	wire gen2_bad = expect_gen2 && (link.link_rate != RATE_GEN2);
	// One retrain per power-up, so a Gen 1 only endpoint cannot loop forever
	wire retrain_now = (state == PLRS_H_CHECK) && gen2_bad && !retrain_count;

	// ==============================
	// Next state
	always_comb
	begin
		next_state = state;
		case (state)
			PLRS_H_RESET:
				if (power_good && hold_done)
					next_state = PLRS_H_RELEASE;
			PLRS_H_RELEASE:
				if (link.link_l0)
					next_state = PLRS_H_CHECK;
			PLRS_H_CHECK:
				next_state = PLRS_H_UP;
			PLRS_H_UP:
				if (!link.link_l0)
					next_state = PLRS_H_RELEASE;
			default:
				next_state = PLRS_H_RESET;
		endcase
		if (!power_good)
			next_state = PLRS_H_RESET;
	end

	// ==============================
	// State, timers, outputs
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= PLRS_H_RESET;
			tick_cnt <= '0;
			ms <= '0;
			link.perst_n <= 1'b0;
			link.retrain_req <= 1'b0;
			link_up <= 1'b0;
			rate_ok <= 1'b0;
			retrain_count <= 1'b0;
		end
		else
		begin
			state <= next_state;
			// Prescaler and timer start from power good, so the hold is a full 100 ms
			tick_cnt <= (ms_tick || !power_good) ? '0 : tick_cnt + 1'b1;
			if (next_state != state || !power_good)
				ms <= '0;
			else if (ms_tick && ms != '1)
				ms <= ms + 1'b1;
			// Link reset held at least 100 ms after power good
			link.perst_n <= (next_state != PLRS_H_RESET);
			// Device waits 20 ms itself is not assumed; training gated by device
			link.retrain_req <= retrain_now;
			retrain_count <= power_good ? (retrain_count ^ retrain_now) : 1'b0;
			link_up <= (next_state == PLRS_H_UP) || (next_state == PLRS_H_CHECK);
			rate_ok <= (state == PLRS_H_CHECK) ? !gen2_bad : (rate_ok && link.link_l0);
		end
	end
endmodule
`default_nettype wire

// [logic/plrs_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Sideband and status signals between host root port and device
interface plrs_link_if;
	logic perst_n; // Host reset toward device, active low
	logic ready_for_training; // Device link ready to train
	logic link_l0; // Device link in active state
	logic [1:0] link_rate; // Trained link rate
	logic retrain_req; // Host request to retrain, one-cycle pulse
	// Device end
	modport dev (input perst_n, input retrain_req, output ready_for_training,
		output link_l0, output link_rate);
	// Host end
	modport host (output perst_n, output retrain_req, input ready_for_training,
		input link_l0, input link_rate);
endinterface
`default_nettype wire

// [logic/plrs_pkg.sv]
package plrs_pkg;
	// Clock period in ns
	localparam int CLK_PERIOD_NS = 10;
	// Cycles in one millisecond
	localparam int CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
	// Timing figures in ms
	localparam int POR_MIN_MS = 4;
	localparam int POR_MAX_MS = 12;
	localparam int PERIPH_DEADLINE_MS = 120;
	localparam int PERST_ACTIVE_MIN_MS = 100;
	localparam int PERST_INACTIVE_MIN_MS = 20;
	localparam int L0_DEADLINE_MS = 100;
	localparam int WAKE_DEADLINE_MS = 200;
	// Default power-on reset delay used by the device, inside 4..12 ms
	localparam int POR_DELAY_MS = 8;
	// Millisecond counter width
	localparam int MS_W = 8;
	// Tick prescaler width
	localparam int TICK_W = 20;
	// Link rate codes
	localparam logic [1:0] RATE_GEN1 = 2'h1;
	localparam logic [1:0] RATE_GEN2 = 2'h2;
	// Configuration modes
	typedef enum logic
	{
		PLRS_MODE_INIT = 1'b0,
		PLRS_MODE_UPDATE = 1'b1
	} plrs_mode_e;
	// Conventional configuration schemes
	typedef enum logic [1:0]
	{
		PLRS_ACTIVE_SERIAL_SCHEME = 2'h0,
		PLRS_PASSIVE_SERIAL_SCHEME = 2'h1,
		PLRS_FAST_PASSIVE_PARALLEL_SCHEME = 2'h2
	} plrs_scheme_e;
endpackage

// [test/plrs_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the link signals between the host and the device ends
module plrs_chk
	import plrs_pkg::*;
#(
	parameter int MS_CYCLES = CYC_PER_MS
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic power_on,
	input wire logic perst_n,
	input wire logic ready_for_training,
	input wire logic link_l0,
	input wire logic [1:0] link_rate,
	input wire logic retrain_req
);
	int low_cnt; // Cycles with link reset held
	int wait_cnt; // Cycles since release without L0
	int up_cnt; // Cycles since power on
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// ==========
	// Millisecond window counters
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			low_cnt <= 0;
			wait_cnt <= 0;
			up_cnt <= 0;
		end
		else
		begin
			low_cnt <= perst_n ? 0 : low_cnt + 1;
			wait_cnt <= (!perst_n || link_l0) ? 0 : wait_cnt + 1;
			up_cnt <= power_on ? up_cnt + 1 : 0;
		end
	end
	// ==========
	// Link reset release seen on the wire
	sequence s_release;
		!perst_n ##1 perst_n;
	endsequence
	a_hold_min: assert property (s_release |-> low_cnt >= PERST_ACTIVE_MIN_MS * MS_CYCLES)
		else $error("link reset released too early");
	a_release_quiet: assert property (s_release |-> !link_l0)
		else $error("link active before reset release");
	a_l0_cause: assert property ($rose(link_l0) |-> $past(perst_n))
		else $error("active state reached while held in reset");
	a_l0_deadline: assert property (wait_cnt <= L0_DEADLINE_MS * MS_CYCLES)
		else $error("active state late after release");
	a_l0_on_reset: assert property (!perst_n |=> !link_l0)
		else $error("active state kept under link reset");
	a_wake_limit: assert property ($rose(link_l0) |-> up_cnt < WAKE_DEADLINE_MS * MS_CYCLES)
		else $error("wake-up took too long");
	a_rate_legal: assert property (link_rate == RATE_GEN1 || link_rate == RATE_GEN2)
		else $error("illegal link rate code");
	a_retrain_pulse: assert property (retrain_req |=> !retrain_req)
		else $error("retrain request longer than one cycle");
	a_retrain_cause: assert property (retrain_req |-> $past(link_rate) != RATE_GEN2)
		else $error("retrain requested at full rate");
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
// Both link ends joined, driven from their user sides
module testbench;
	import plrs_pkg::*;
	logic clk, nrst, supplies_good, strap, config_done, training_done;
	logic gen2_capable, power_good, expect_gen2;
	plrs_mode_e mode;
	plrs_scheme_e config_scheme;
	logic core_reset_n, config_start, hard_reset_pulse, link_app_enable, core_image_over_link;
	logic config_timeout, l0_timeout, wake_timeout, scheme_error, link_up, rate_ok, retrain_count;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0; // Free-running cycle count
	int n_hard = 0; // Hard reset pulses seen
	int t0, n, h;
	localparam int MS = 100; // Cycles per millisecond, shortened for the run
	plrs_link_if link_bus();
	plrs_device #(.MS_CYCLES(MS)) plrs_device_inst (.clk(clk), .nrst(nrst), .link(link_bus.dev),
		.supplies_good(supplies_good), .reset_delay_select_strap(strap), .mode(mode),
		.config_scheme(config_scheme), .config_done(config_done), .training_done(training_done),
		.gen2_capable(gen2_capable), .core_reset_n(core_reset_n), .config_start(config_start),
		.hard_reset_pulse(hard_reset_pulse), .link_app_enable(link_app_enable),
		.core_image_over_link(core_image_over_link), .config_timeout(config_timeout),
		.l0_timeout(l0_timeout), .wake_timeout(wake_timeout), .scheme_error(scheme_error));
	plrs_host #(.MS_CYCLES(MS)) plrs_host_inst (.clk(clk), .nrst(nrst), .link(link_bus.host),
		.power_good(power_good), .expect_gen2(expect_gen2), .link_up(link_up),
		.rate_ok(rate_ok), .retrain_count(retrain_count));
	plrs_chk #(.MS_CYCLES(MS)) plrs_chk_inst (.clk(clk), .nrst(nrst), .power_on(supplies_good),
		.perst_n(link_bus.perst_n),
		.ready_for_training(link_bus.ready_for_training), .link_l0(link_bus.link_l0),
		.link_rate(link_bus.link_rate), .retrain_req(link_bus.retrain_req));
	// Clock at 100 MHz
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Cycle and pulse counting, away from the launching edge
	always @(negedge clk)
	begin
		cyc <= cyc + 1;
		if (hard_reset_pulse === 1'b1)
			n_hard <= n_hard + 1;
	end
	// ==========
	// Checking helpers
	task check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch time=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Selects the signal awaited
	function logic sel(input int w);
		case (w)
			0: sel = config_start;
			1: sel = hard_reset_pulse;
			2: sel = link_bus.perst_n;
			default: sel = link_bus.link_l0;
		endcase
	endfunction
	// Waits at falling edges for a high level, bounded
	task wait_hi(input int w, input int lim, output int k);
		k = 0;
		while (sel(w) !== 1'b1 && k < lim)
		begin
			@(negedge clk);
			k++;
		end
	endtask
	// Powers the device and lets the conventional load finish
	task power(input plrs_scheme_e s, input plrs_mode_e m);
		@(negedge clk);
		config_scheme = s;
		mode = m;
		supplies_good = 1'b1;
		t0 = cyc;
		@(negedge clk);
		check(core_reset_n, 0);
		wait_hi(0, POR_MAX_MS * MS + 10, n);
		check(n >= POR_MIN_MS * MS - 2 && n <= POR_MAX_MS * MS, 1);
		repeat ($urandom_range(1, 200)) @(negedge clk);
		config_done = 1'b1;
	endtask
	// ==========
	// Main sequence
	initial
	begin
		void'($urandom(32'hCBA9));
		{nrst, supplies_good, config_done, training_done, power_good} = 5'h00;
		{gen2_capable, expect_gen2} = 2'h3;
		strap = 1'b1;
		mode = PLRS_MODE_INIT;
		config_scheme = PLRS_ACTIVE_SERIAL_SCHEME;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		check({link_bus.perst_n, link_bus.link_l0, link_bus.link_rate, core_reset_n}, 5'h02);
		// Illegal scheme is refused, without a hard reset pulse
		config_scheme = plrs_scheme_e'(2'h3);
		supplies_good = 1'b1;
		config_done = 1'b1;
		repeat (POR_MAX_MS * MS + 10) @(negedge clk);
		check({scheme_error, n_hard[0]}, 2'h2);
		// Stuck load runs into both deadlines
		repeat ((WAKE_DEADLINE_MS - POR_MAX_MS + 1) * MS) @(negedge clk);
		check({config_timeout, wake_timeout}, 2'h3);
		config_done = 1'b0;
		supplies_good = 1'b0;
		repeat (2) @(negedge clk);
		check({core_reset_n, config_timeout, l0_timeout, wake_timeout}, 0);
		// Every legal scheme in initialization mode
		for (int s = 0; s < 3; s++)
		begin
			power(plrs_scheme_e'(s[1:0]), PLRS_MODE_INIT);
			wait_hi(1, 16, n);
			check(n < 16, 1);
			check(cyc - t0 < PERIPH_DEADLINE_MS * MS, 1);
			check({scheme_error, core_reset_n}, 2'h1);
			config_done = 1'b0;
			supplies_good = 1'b0;
			@(negedge clk);
		end
		// Full wake-up in update mode with the host end
		h = n_hard;
		gen2_capable = 1'($urandom_range(0, 1));
		power_good = 1'b1;
		power(plrs_scheme_e'($urandom_range(0, 2)), PLRS_MODE_UPDATE);
		check(cyc - t0 < PERIPH_DEADLINE_MS * MS, 1);
		wait_hi(2, 110 * MS, n);
		check(cyc - t0 >= PERST_ACTIVE_MIN_MS * MS, 1);
		repeat (PERST_INACTIVE_MIN_MS * MS) @(negedge clk);
		training_done = 1'b1;
		wait_hi(3, 4, n);
		check(n < 4, 1);
		check(cyc - t0 < WAKE_DEADLINE_MS * MS, 1);
		repeat (8) @(negedge clk);
		check({link_app_enable, core_image_over_link, link_up}, 3'h7);
		check(link_bus.link_rate, gen2_capable ? 32'h2 : 32'h1);
		check({rate_ok, retrain_count}, gen2_capable ? 32'h2 : 32'h1);
		check(n_hard, h);
		check({config_timeout, l0_timeout, wake_timeout}, 0);
		repeat (50) @(negedge clk);
		stop_test;
	end
	// Watchdog: the run needs about 35,000 cycles, this allows 60,000
	initial
	begin
		#(64'd600_000);
		n_mismatch++;
		stop_test;
	end
endmodule
`default_nettype wire
